/* File: logic/listen_pkg.sv */
// Constants and types shared by the listen-mode duty cycler
//
// Summary of operation
// - The 2-bit idle unit picks 64 us, 4.1 ms or 262 ms from the RC time base for 01, 10 and 11; code 00 is reserved.
// - The 2-bit receive unit gives 64 us for 01, 4.1 ms for 10 and 262 ms for 11; 00 is reserved.
// - The idle phase lasts the 8-bit idle coefficient times the idle unit; the coefficient resets to 0xf5.
// - The receive phase lasts the receive coefficient times the receive unit, startup included; reset 0x20.
// - Criterion 0 accepts on signal strength above the limit; criterion 1 also needs a sync match.
// - End action 00 keeps receive on and stops the sequence until the host clears listen enable.
// - End action 01 waits for payload complete or timeout, then takes the stored mode and stops.
// - End action 10 waits for payload complete or timeout, then resumes in idle; buffered data is dropped at the next receive wakeup.
// - The read-only revision register holds the full revision high and the metal revision low.
package listen_pkg;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [5:0] IDX_TIMING = 6'h0d;
  localparam logic [5:0] IDX_COEF_IDLE = 6'h0e;
  localparam logic [5:0] IDX_COEF_RX = 6'h0f;
  localparam logic [5:0] IDX_REVISION = 6'h10;
  localparam logic [5:0] IDX_CONTROL = 6'h11;
  localparam logic [5:0] IDX_STATUS = 6'h12;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int POS_IDLE_UNIT = 6;
  localparam int POS_RX_UNIT = 4;
  localparam int POS_CRITERION = 3;
  localparam int POS_END_ACTION = 1;
  localparam int POS_ENABLE = 0;
  localparam int POS_MODE = 1;
  localparam logic [1:0] RST_IDLE_UNIT = 2'h2;
  localparam logic [1:0] RST_RX_UNIT = 2'h1;
  localparam logic RST_CRITERION = 1'b0;
  localparam logic [1:0] RST_END_ACTION = 2'h1;
  localparam logic [7:0] RST_COEF_IDLE = 8'hf5;
  localparam logic [7:0] RST_COEF_RX = 8'h20;
  localparam logic [2:0] RST_MODE = 3'h0;

  localparam logic [1:0] END_HOLD_RX = 2'h0;
  localparam logic [1:0] END_GO_MODE = 2'h1;
  localparam logic [1:0] END_RESUME = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int T_UNIT_FINE_US = 64;
  localparam int T_UNIT_MID_US = 4100;
  localparam int T_UNIT_COARSE_US = 262000;
  localparam int UNIT_FINE_CYCLES = T_UNIT_FINE_US * CLK_MHZ;
  localparam int UNIT_MID_CYCLES = T_UNIT_MID_US * CLK_MHZ;
  localparam int UNIT_COARSE_CYCLES = T_UNIT_COARSE_US * CLK_MHZ;

  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_IDLE = 6'h02,
    ST_RX = 6'h04,
    ST_HOLD = 6'h08,
    ST_WAIT = 6'h10,
    ST_STOPPED = 6'h20
  } phase_t;

endpackage

/* File: logic/unit_tick_if.sv */
// Link between the sequencer and its time-unit generator
`timescale 1ns/10ps
interface unit_tick_if;
  logic restart;
  logic [1:0] unit_sel;
  logic tick;
  modport sequencer (output restart, output unit_sel, input tick);
  modport generator (input restart, input unit_sel, output tick);
endinterface

/* File: logic/unit_tick_gen.sv */
// Time-unit generator: one-cycle tick per selected unit
`timescale 1ns/10ps
module unit_tick_gen
  import listen_pkg::*;
#(
  parameter int unsigned FINE_CYCLES = UNIT_FINE_CYCLES,
  parameter int unsigned MID_CYCLES = UNIT_MID_CYCLES,
  parameter int unsigned COARSE_CYCLES = UNIT_COARSE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  unit_tick_if.generator link
);

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } gen_t;

  gen_t s;
  gen_t next_s;

  // Reserved code 00 falls back to the finest unit
  function automatic logic [31:0] unit_len(input logic [1:0] sel);
    unique case (sel)
      2'h2: unit_len = MID_CYCLES;
      2'h3: unit_len = COARSE_CYCLES;
      default: unit_len = FINE_CYCLES;
    endcase
  endfunction

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (link.restart) begin
      next_s.cnt = 32'h0;
    end else if (s.cnt >= unit_len(link.unit_sel) - 32'h1) begin
      next_s.cnt = 32'h0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 32'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.tick = s.tick;

endmodule // unit_tick_gen

/* File: logic/listen_duty_cycler.sv */
// Listen-mode duty cycler with AXI4-Lite register slave
`timescale 1ns/10ps
module listen_duty_cycler
  import listen_pkg::*;
#(
  parameter int unsigned FINE_CYCLES = UNIT_FINE_CYCLES,
  parameter int unsigned MID_CYCLES = UNIT_MID_CYCLES,
  parameter int unsigned COARSE_CYCLES = UNIT_COARSE_CYCLES,
  parameter logic [3:0] REV_FULL = 4'h1,  // Arbitrary value
  parameter logic [3:0] REV_METAL = 4'h0  // Arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic signal_strength_limit,
  input wire logic sync_match,
  input wire logic payload_complete,
  input wire logic rx_timeout,
  output logic rx_on,
  output logic listen_active,
  output logic [2:0] op_mode,
  output logic fifo_flush
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    phase_t st;
    logic [7:0] cnt;
    logic restart;
    logic rx_on;
    logic listening;
    logic [2:0] op_mode;
    logic fifo_flush;
    logic discard;
    logic [1:0] idle_unit;
    logic [1:0] rx_unit;
    logic crit;
    logic [1:0] end_act;
    logic [7:0] coef_idle;
    logic [7:0] coef_rx;
    logic en;
    logic [2:0] mode;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dc_t;

  dc_t s;
  dc_t next_s;
  unit_tick_if tl ();

  unit_tick_gen #(
    .FINE_CYCLES(FINE_CYCLES),
    .MID_CYCLES(MID_CYCLES),
    .COARSE_CYCLES(COARSE_CYCLES)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .link(tl.generator)
  );

  function automatic logic mapped(input logic [7:0] addr);
    mapped = addr[7:2] >= IDX_TIMING && addr[7:2] <= IDX_STATUS;
  endfunction

  // ------------------------------------------------------------
  // Combinational helpers
  // ------------------------------------------------------------
  logic accept;
  logic phase_done;
  logic rx_done;
  logic [7:0] cur_coef;

  always_comb begin
    accept = signal_strength_limit && (!s.crit || sync_match);
    rx_done = payload_complete || rx_timeout;
    cur_coef = (s.st == ST_RX) ? s.coef_rx : s.coef_idle;
    phase_done = (s.cnt == cur_coef);
  end

  // Unit choice follows the phase being timed
  assign tl.unit_sel = (s.st == ST_RX) ? s.rx_unit : s.idle_unit;
  assign tl.restart = s.restart;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.restart = 1'b0;
    next_s.fifo_flush = 1'b0;

    // Write channel
    if (s.awready && s_axi_awvalid) begin
      next_s.awaddr = s_axi_awaddr;
      next_s.aw_have = 1'b1;
      next_s.awready = 1'b0;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
      next_s.w_have = 1'b1;
      next_s.wready = 1'b0;
    end
    if (s.aw_have && s.w_have && !s.bvalid) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(s.awaddr) ? RESP_OKAY : RESP_DECERR;
      if (s.wstrb[0]) begin
        unique case (s.awaddr[7:2])
          IDX_TIMING: begin
            next_s.idle_unit = s.wdata[POS_IDLE_UNIT +: 2];
            next_s.rx_unit = s.wdata[POS_RX_UNIT +: 2];
            next_s.crit = s.wdata[POS_CRITERION];
            next_s.end_act = s.wdata[POS_END_ACTION +: 2];
          end
          IDX_COEF_IDLE: next_s.coef_idle = s.wdata[7:0];
          IDX_COEF_RX: next_s.coef_rx = s.wdata[7:0];
          IDX_CONTROL: begin
            next_s.en = s.wdata[POS_ENABLE];
            next_s.mode = s.wdata[POS_MODE +: 3];
          end
          default: ;
        endcase
      end
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    // Read channel
    if (s.arready && s_axi_arvalid) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      unique case (s_axi_araddr[7:2])
        IDX_TIMING: next_s.rdata = {24'h0, s.idle_unit, s.rx_unit, s.crit, s.end_act, 1'b0};
        IDX_COEF_IDLE: next_s.rdata = {24'h0, s.coef_idle};
        IDX_COEF_RX: next_s.rdata = {24'h0, s.coef_rx};
        IDX_REVISION: next_s.rdata = {24'h0, REV_FULL, REV_METAL};
        IDX_CONTROL: next_s.rdata = {28'h0, s.mode, s.en};
        IDX_STATUS: next_s.rdata = {24'h0, s.discard, s.rx_on, s.st};
        default: next_s.rdata = 32'h0;
      endcase
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    // Sequencer
    // A tick in the restart cycle belongs to the old phase
    if (tl.tick && !s.restart) begin
      next_s.cnt = s.cnt + 8'h1;
    end
    unique case (s.st)
      ST_OFF: begin
        if (s.en) begin
          next_s.st = ST_IDLE;
          next_s.cnt = 8'h0;
          next_s.restart = 1'b1;
          next_s.listening = 1'b1;
        end
      end
      ST_IDLE: begin
        if (phase_done) begin
          next_s.st = ST_RX;
          next_s.cnt = 8'h0;
          next_s.restart = 1'b1;
          next_s.rx_on = 1'b1;
          next_s.fifo_flush = s.discard;
          next_s.discard = 1'b0;
        end
      end
      ST_RX: begin
        if (accept) begin
          next_s.st = (s.end_act == END_HOLD_RX) ? ST_HOLD : ST_WAIT;
        end else if (phase_done) begin
          next_s.st = ST_IDLE;
          next_s.cnt = 8'h0;
          next_s.restart = 1'b1;
          next_s.rx_on = 1'b0;
        end
      end
      ST_HOLD: ;
      ST_WAIT: begin
        if (rx_done) begin
          if (s.end_act == END_GO_MODE) begin
            next_s.st = ST_STOPPED;
            next_s.op_mode = s.mode;
            next_s.rx_on = 1'b0;
            next_s.listening = 1'b0;
          end else begin
            next_s.st = ST_IDLE;
            next_s.cnt = 8'h0;
            next_s.restart = 1'b1;
            next_s.rx_on = 1'b0;
            next_s.discard = 1'b1;
          end
        end
      end
      ST_STOPPED: ;
      default: next_s.st = ST_OFF;
    endcase
    if (s.st == ST_HOLD) begin
      next_s.listening = 1'b0;
    end
    // Clearing enable always wins; the host must do it after a stop
    if (!s.en) begin
      next_s.st = ST_OFF;
      next_s.rx_on = 1'b0;
      next_s.listening = 1'b0;
      next_s.discard = 1'b0;
      next_s.fifo_flush = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.st <= ST_OFF;
      s.idle_unit <= RST_IDLE_UNIT;
      s.rx_unit <= RST_RX_UNIT;
      s.crit <= RST_CRITERION;
      s.end_act <= RST_END_ACTION;
      s.coef_idle <= RST_COEF_IDLE;
      s.coef_rx <= RST_COEF_RX;
      s.mode <= RST_MODE;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign rx_on = s.rx_on;
  assign listen_active = s.listening;
  assign op_mode = s.op_mode;
  assign fifo_flush = s.fifo_flush;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_IDLE_UNIT: assert property (s.st == ST_IDLE |-> tl.unit_sel == s.idle_unit)
    else $error("idle phase timed with wrong unit");
  AST_RX_UNIT: assert property (s.st == ST_RX |-> tl.unit_sel == s.rx_unit)
    else $error("receive phase timed with wrong unit");
  AST_IDLE_LEN: assert property (s.st == ST_IDLE && s.en |-> s.cnt <= s.coef_idle)
    else $error("idle phase ran past its coefficient");
  AST_RX_LEN: assert property (s.st == ST_RX && s.en && !accept |-> s.cnt <= s.coef_rx)
    else $error("receive phase ran past its coefficient");
  AST_ACCEPT: assert property (s.st == ST_RX && s.en && !signal_strength_limit
    |=> s.st != ST_HOLD && s.st != ST_WAIT)
    else $error("packet accepted without signal strength");
  AST_HOLD: assert property (s.st == ST_HOLD && s.en |=> s.st == ST_HOLD && rx_on)
    else $error("hold state left while enabled");
  AST_GO_MODE: assert property (s.st == ST_WAIT && s.en && rx_done && s.end_act == END_GO_MODE
    |=> s.st == ST_STOPPED && op_mode == $past(s.mode) && !rx_on)
    else $error("stored mode not taken after packet");
  AST_RESUME: assert property (s.st == ST_WAIT && s.en && rx_done && s.end_act == END_RESUME
    |=> s.st == ST_IDLE ##1 (s.st != ST_IDLE || s.cnt == 8'h0 || !s.en))
    else $error("listen cycle not resumed in idle");
  AST_FLUSH: assert property (fifo_flush |-> s.st == ST_RX && $past(s.discard))
    else $error("buffer flush outside a receive wakeup");
  AST_REVISION: assert property (s.arready && s_axi_arvalid && s_axi_araddr[7:2] == IDX_REVISION
    |=> s_axi_rdata[7:0] == {REV_FULL, REV_METAL})
    else $error("revision register mismatch");
  AST_ALTERNATE: assert property (s.st == ST_IDLE && s.en && phase_done
    |=> s.st == ST_RX && rx_on && s.cnt == 8'h0)
    else $error("receive phase not started after idle");

  COV_CYCLE: cover property (s.st == ST_IDLE ##1 s.st == ST_RX);
  COV_HOLD: cover property (s.st == ST_RX ##1 s.st == ST_HOLD);
  COV_STOP: cover property (s.st == ST_WAIT ##1 s.st == ST_STOPPED);
  COV_FLUSH: cover property (fifo_flush);

endmodule // listen_duty_cycler

/* File: verification/listen_tb.sv */
// Self-checking bench for the listen-mode duty cycler
`timescale 1ns/10ps
module testbench;
  import listen_pkg::*;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  // Short units keep every phase within a few dozen cycles
  localparam int FINE = 4;
  localparam int MID = 8;
  localparam int COARSE = 16;
  localparam int LIMIT = 20000;
  typedef struct {
    logic [7:0] addr;
    logic [7:0] data;
    logic [1:0] resp;
  } row_t;
  logic aclk;
  logic aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, strength = 1'b0, sync = 1'b0;
  logic payload = 1'b0, timeout = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, rx_on, listen_active, fifo_flush;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic [2:0] op_mode;
  int num_errors, compares, cycles;
  row_t rows [6] = '{'{8'h34, 8'h92, RESP_OKAY}, '{8'h38, 8'hf5, RESP_OKAY},
    '{8'h3c, 8'h20, RESP_OKAY}, '{8'h40, 8'h10, RESP_OKAY}, '{8'h44, 8'h00, RESP_OKAY},
    '{8'hfc, 8'h00, RESP_DECERR}};

  listen_duty_cycler #(.FINE_CYCLES(FINE), .MID_CYCLES(MID), .COARSE_CYCLES(COARSE)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .signal_strength_limit(strength), .sync_match(sync), .payload_complete(payload),
    .rx_timeout(timeout), .rx_on(rx_on), .listen_active(listen_active), .op_mode(op_mode),
    .fifo_flush(fifo_flush)
  );

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors = num_errors + 1;
      stop_test();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, num_errors);
  endtask

  // Ready is looked at on the falling edge, where nothing moves
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
    logic aw_hit, w_hit, b_hit;
    logic [1:0] r;
    awaddr <= a;
    wdata <= {24'h000000, v};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      b_hit = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end while (!b_hit);
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
    logic ar_hit, r_hit;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_hit = arvalid && arready;
      r_hit = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_hit) arvalid <= 1'b0;
    end while (!r_hit);
    rready <= 1'b0;
    chk(d, {24'h000000, exp});
    chk({30'h0, r}, {30'h0, er});
    @(posedge aclk);
  endtask

  // Counts cycles until the receiver reaches the given level
  task automatic wait_rx(input logic lvl, output int n);
    n = 0;
    do begin
      @(negedge aclk);
      n = n + 1;
    end while (rx_on !== lvl && n < 2000);
    chk({31'h0, rx_on}, {31'h0, lvl});
    @(posedge aclk);
  endtask

  function automatic logic [7:0] tval(input logic [1:0] iu, input logic [1:0] ru,
      input logic crit, input logic [1:0] act);
    return {iu, ru, crit, act, 1'b0};
  endfunction

  function automatic int unit_len(input int c);
    return (c == 1) ? FINE : (c == 2) ? MID : COARSE;
  endfunction

  // Phase entry adds three cycles to the nominal length
  function automatic logic [31:0] in_range(input int n, input int e);
    return {31'h0, (n >= e) && (n <= e + 4)};
  endfunction

  task automatic run_table();
    foreach (rows[i]) begin
      rd(rows[i].addr, rows[i].data, rows[i].resp);
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n;
    logic got;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    run_table();
    end_test("register reset values");
    wr(8'h40, 8'hff, RESP_OKAY);
    wr(8'hfc, 8'h11, RESP_DECERR);
    rd(8'h40, 8'h10, RESP_OKAY);
    wr(8'h38, 8'h02, RESP_OKAY);
    rd(8'h38, 8'h02, RESP_OKAY);
    end_test("register access");
    for (int u = 1; u < 4; u++) begin
      wr(8'h44, 8'h00, RESP_OKAY);
      wr(8'h34, tval(2'(u), 2'(u), 1'b0, END_GO_MODE), RESP_OKAY);
      wr(8'h3c, 8'h01, RESP_OKAY);
      wr(8'h44, 8'h01, RESP_OKAY);
      wait_rx(1'b1, n);
      wait_rx(1'b0, n);
      chk(in_range(n, unit_len(u)), 32'h1);
      wait_rx(1'b1, n);
      chk(in_range(n, 2 * unit_len(u)), 32'h1);
    end
    end_test("phase timing per unit");
    wr(8'h44, 8'h00, RESP_OKAY);
    wr(8'h34, tval(2'h1, 2'h1, 1'b1, END_GO_MODE), RESP_OKAY);
    wr(8'h3c, 8'h04, RESP_OKAY);
    strength <= 1'b1;
    wr(8'h44, 8'h0b, RESP_OKAY);
    wait_rx(1'b1, n);
    wait_rx(1'b0, n);
    chk(in_range(n, 4 * FINE), 32'h1);
    sync <= 1'b1;
    wait_rx(1'b1, n);
    repeat (8 * FINE) @(posedge aclk);
    rd(8'h48, 8'h50, RESP_OKAY);
    payload <= 1'b1;
    @(posedge aclk);
    payload <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(8'h48, 8'h20, RESP_OKAY);
    @(negedge aclk);
    chk({28'h0, op_mode, listen_active}, 32'ha);
    @(posedge aclk);
    sync <= 1'b0;
    end_test("sync criterion and stored mode");
    wr(8'h44, 8'h00, RESP_OKAY);
    wr(8'h34, tval(2'h1, 2'h1, 1'b0, END_HOLD_RX), RESP_OKAY);
    wr(8'h44, 8'h01, RESP_OKAY);
    wait_rx(1'b1, n);
    repeat (8 * FINE) @(posedge aclk);
    rd(8'h48, 8'h48, RESP_OKAY);
    @(negedge aclk);
    chk({30'h0, rx_on, listen_active}, 32'h2);
    @(posedge aclk);
    wr(8'h44, 8'h00, RESP_OKAY);
    rd(8'h48, 8'h01, RESP_OKAY);
    end_test("hold in receive");
    wr(8'h34, tval(2'h1, 2'h1, 1'b0, END_RESUME), RESP_OKAY);
    wr(8'h44, 8'h01, RESP_OKAY);
    wait_rx(1'b1, n);
    strength <= 1'b0;
    repeat (8 * FINE) @(posedge aclk);
    timeout <= 1'b1;
    @(posedge aclk);
    timeout <= 1'b0;
    wait_rx(1'b0, n);
    chk({31'h0, n <= 4}, 32'h1);
    rd(8'h48, 8'h82, RESP_OKAY);
    got = 1'b0;
    repeat (4 * COARSE) begin
      @(negedge aclk);
      if (fifo_flush === 1'b1) got = 1'b1;
    end
    @(posedge aclk);
    chk({31'h0, got}, 32'h1);
    end_test("resume after timeout");
    // Reset lands while the sequence is still running
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk({24'h0, bvalid, rvalid, rx_on, listen_active, fifo_flush, op_mode}, 32'h0);
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    run_table();
    end_test("reset in mid run");
    stop_test();
  end
endmodule // testbench
